// >>> shared/mult_pkg.sv
// Package for the hardened multiplier block: widths, reset values, carriers.
// Assumes one clock domain; all users import the whole package.
package mult_pkg;

  localparam int unsigned FULL_W    = 18;
  localparam int unsigned HALF_W    = 9;
  localparam int unsigned PROD_W    = 2 * FULL_W;
  localparam int unsigned HALF_PROD = 2 * HALF_W;
  localparam int unsigned LATENCY_DIRECT = 1;
  localparam int unsigned LATENCY_REG    = 2;

  localparam logic [FULL_W-1:0] OPERAND_RESET = 18'h00000;
  localparam logic [PROD_W-1:0] PRODUCT_RESET = 36'h000000000;

  // Static configuration of one block
  typedef struct packed {
    logic dual;
    logic regA;
    logic regB;
    logic regSign;
  } mult_cfg_t;

  // Operands and sign controls from the fabric
  typedef struct packed {
    logic [FULL_W-1:0] dataA;
    logic [FULL_W-1:0] dataB;
    logic              signA;
    logic              signB;
  } mult_in_t;

  // Registered result
  typedef struct packed {
    logic [PROD_W-1:0] product;
    logic              resultSigned;
  } mult_out_t;

endpackage : mult_pkg

// >>> rtl/mult_lane.sv
// One combinational multiplier lane with per-operand sign control.
// Assumes operands already selected (registered or direct) by the caller.
`timescale 1ns/10ps
module mult_lane
  import mult_pkg::*;
#(
  parameter int unsigned W = 18
) (
  // Operands
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  input  wire logic           signA,
  input  wire logic           signB,
  // Full precision product
  output logic      [2*W-1:0] product
);

  logic signed [W:0]     extA;
  logic signed [W:0]     extB;
  logic signed [2*W+1:0] full;

  // One extra bit makes unsigned and signed share a signed multiplier
  assign extA    = {signA & a[W-1], a};
  assign extB    = {signB & b[W-1], b};
  assign full    = extA * extB;
  assign product = full[2*W-1:0];

endmodule : mult_lane

// >>> rtl/hard_multiplier_block.sv
// Hardened multiplier block: one 18x18 or two 9x9 multipliers.
// Assumes synchronous operands; aclr is the block's own asynchronous clear.
//
// What this block does
// - One 18x18 or two independent 9x9 multipliers
// - Operands go registered or direct, 9/18 sections
// - Registered or direct chosen per operand input
// - Input registers have clock, enable, clear
// - All registers share clock, enable, clear
// - Sign input high means operand is signed
// - Signed result if either operand signed
// - Product registered in 18 or 36 bit sections
// - Dual mode shares one sign per operand
`timescale 1ns/10ps
module hard_multiplier_block
  import mult_pkg::*;
(
  // Clock, reset and shared register controls
  input  wire logic      mclk,
  input  wire logic      nrst,
  input  wire logic      ce,
  input  wire logic      aclr,
  // Configuration
  input  wire mult_cfg_t cfg,
  // Operands from the fabric
  input  wire mult_in_t  in,
  // Result
  output mult_out_t      out
);

  typedef struct packed {
    logic [FULL_W-1:0] regA;
    logic [FULL_W-1:0] regB;
    logic              signA;
    logic              signB;
    mult_out_t         res;
  } mult_state_t;

  mult_state_t st;
  mult_state_t next_st;

  logic [FULL_W-1:0]    coreA;
  logic [FULL_W-1:0]    coreB;
  logic                 coreSignA;
  logic                 coreSignB;
  logic [PROD_W-1:0]    prodFull;
  logic [HALF_PROD-1:0] prodLo;
  logic [HALF_PROD-1:0] prodHi;

  // Per-operand bypass of the data input registers; regSign bypasses both sign registers together
  assign coreA     = cfg.regA ? st.regA : in.dataA;
  assign coreB     = cfg.regB ? st.regB : in.dataB;
  assign coreSignA = cfg.regSign ? st.signA : in.signA;
  assign coreSignB = cfg.regSign ? st.signB : in.signB;

  mult_lane #(.W(FULL_W)) laneFull (
    .a       (coreA),
    .b       (coreB),
    .signA   (coreSignA),
    .signB   (coreSignB),
    .product (prodFull)
  );

  // Both halves see the same sign pair in dual mode
  mult_lane #(.W(HALF_W)) laneLo (
    .a       (coreA[HALF_W-1:0]),
    .b       (coreB[HALF_W-1:0]),
    .signA   (coreSignA),
    .signB   (coreSignB),
    .product (prodLo)
  );

  mult_lane #(.W(HALF_W)) laneHi (
    .a       (coreA[FULL_W-1:HALF_W]),
    .b       (coreB[FULL_W-1:HALF_W]),
    .signA   (coreSignA),
    .signB   (coreSignB),
    .product (prodHi)
  );

  always_comb begin
    next_st       = st;
    next_st.regA  = in.dataA;
    next_st.regB  = in.dataB;
    next_st.signA = in.signA;
    next_st.signB = in.signB;
    if (cfg.dual) begin
      next_st.res.product = {prodHi, prodLo};
    end else begin
      next_st.res.product = prodFull;
    end
    next_st.res.resultSigned = coreSignA | coreSignB;
  end

  // One clock, one enable, one clear for every register of the block
  always_ff @(posedge mclk or posedge aclr) begin
    if (aclr) begin
      st <= '0;
    end else if (!nrst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign out = st.res;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst || aclr);

  // Antecedents use sampled enable, reset and clear: the registers obey
  // the values seen at the edge, while the disable sees the later ones
  logic directCfg;
  logic quietSigns;
  logic takeEdge;
  logic holdEdge;
  assign directCfg  = !cfg.regA && !cfg.regB && !cfg.regSign;
  assign quietSigns = !in.signA && !in.signB;
  assign takeEdge   = ce && nrst && !aclr;
  assign holdEdge   = !ce && nrst && !aclr;

  AST_FULL_UNSIGNED: assert property (
    takeEdge && directCfg && !cfg.dual && quietSigns |=>
      out.product == {18'h00000, $past(in.dataA)} * {18'h00000, $past(in.dataB)}
  ) else $error("unsigned 18x18 product wrong");

  AST_FULL_SIGNED: assert property (
    takeEdge && directCfg && !cfg.dual && in.signA && in.signB |=>
      out.product == $signed({{18{$past(in.dataA[17])}}, $past(in.dataA)})
                   * $signed({{18{$past(in.dataB[17])}}, $past(in.dataB)})
  ) else $error("signed 18x18 product wrong");

  AST_DUAL_UNSIGNED: assert property (
    takeEdge && directCfg && cfg.dual && quietSigns |=>
      out.product[17:0] == {9'h000, $past(in.dataA[8:0])} * {9'h000, $past(in.dataB[8:0])}
      && out.product[35:18] == {9'h000, $past(in.dataA[17:9])}
                             * {9'h000, $past(in.dataB[17:9])}
  ) else $error("dual 9x9 unsigned lanes wrong");

  AST_DUAL_SIGNED: assert property (
    takeEdge && directCfg && cfg.dual && in.signA && in.signB |=>
      out.product[17:0] == $signed({{9{$past(in.dataA[8])}}, $past(in.dataA[8:0])})
                         * $signed({{9{$past(in.dataB[8])}}, $past(in.dataB[8:0])})
      && out.product[35:18] == $signed({{9{$past(in.dataA[17])}}, $past(in.dataA[17:9])})
                             * $signed({{9{$past(in.dataB[17])}}, $past(in.dataB[17:9])})
  ) else $error("dual 9x9 signed lanes wrong");

  AST_DUAL_MIXED: assert property (
    takeEdge && directCfg && cfg.dual && in.signA && !in.signB |=>
      out.product[17:0] == $signed({{9{$past(in.dataA[8])}}, $past(in.dataA[8:0])})
                         * $signed({9'h000, $past(in.dataB[8:0])})
      && out.product[35:18] == $signed({{9{$past(in.dataA[17])}}, $past(in.dataA[17:9])})
                             * $signed({9'h000, $past(in.dataB[17:9])})
  ) else $error("dual 9x9 signed by unsigned lanes wrong");

  AST_REG_A_ONLY: assert property (
    (takeEdge && cfg.regA && !cfg.regB && !cfg.regSign && !cfg.dual && quietSigns) ##1
    (takeEdge && cfg.regA && !cfg.regB && !cfg.regSign && !cfg.dual && quietSigns) |=>
      out.product == {18'h00000, $past(in.dataA, 2)} * {18'h00000, $past(in.dataB)}
  ) else $error("registered A with direct B misaligned");

  AST_REG_B_ONLY: assert property (
    (takeEdge && !cfg.regA && cfg.regB && !cfg.regSign && !cfg.dual && quietSigns) ##1
    (takeEdge && !cfg.regA && cfg.regB && !cfg.regSign && !cfg.dual && quietSigns) |=>
      out.product == {18'h00000, $past(in.dataA)} * {18'h00000, $past(in.dataB, 2)}
  ) else $error("direct A with registered B misaligned");

  AST_BOTH_REG: assert property (
    (takeEdge && cfg.regA && cfg.regB && !cfg.regSign && !cfg.dual) ##1
    (takeEdge && cfg.regA && cfg.regB && !cfg.regSign && !cfg.dual && quietSigns) |=>
      out.product == {18'h00000, $past(in.dataA, 2)} * {18'h00000, $past(in.dataB, 2)}
  ) else $error("both operands registered misaligned");

  // Enable low freezes every register, result and inputs alike
  AST_HOLD: assert property (
    holdEdge |=> $stable(out.product) && $stable(out.resultSigned)
  ) else $error("result moved while enable low");

  AST_HOLD_REGS: assert property (
    holdEdge |=> $stable(st.regA) && $stable(st.regB) && $stable(st.signA)
  ) else $error("input registers moved while enable low");

  // Clear is watched on its own, outside the default disable
  AST_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
    aclr |-> out.product == PRODUCT_RESET && !out.resultSigned && st.regA == OPERAND_RESET
  ) else $error("clear did not zero the registers");

  AST_SIGN_DIRECT: assert property (
    takeEdge && !cfg.regSign |=> out.resultSigned == ($past(in.signA) | $past(in.signB))
  ) else $error("result sign wrong");

  AST_SIGN_REG: assert property (
    (takeEdge && cfg.regSign) ##1 (takeEdge && cfg.regSign) |=>
      out.resultSigned == ($past(in.signA, 2) | $past(in.signB, 2))
  ) else $error("registered sign path misaligned");

  AST_RESULT_UNSIGNED: assert property (
    takeEdge && !cfg.regSign && quietSigns |=> !out.resultSigned
  ) else $error("unsigned operands gave signed result");

  AST_MIXED_SIGN: assert property (
    takeEdge && directCfg && !cfg.dual && in.signA && !in.signB |=>
      out.product == $signed({{18{$past(in.dataA[17])}}, $past(in.dataA)})
                   * $signed({18'h00000, $past(in.dataB)})
  ) else $error("signed by unsigned product wrong");

  AST_MIXED_SIGN_B: assert property (
    takeEdge && directCfg && !cfg.dual && !in.signA && in.signB |=>
      out.product == $signed({18'h00000, $past(in.dataA)})
                   * $signed({{18{$past(in.dataB[17])}}, $past(in.dataB)})
      && out.resultSigned
  ) else $error("unsigned by signed product wrong");

  // Scenarios the bench should reach
  COV_DUAL:    cover property (ce && cfg.dual ##1 ce && cfg.dual);
  COV_BOTHREG: cover property (ce && cfg.regA && cfg.regB ##1 ce ##1 ce);
  COV_HOLD:    cover property (!ce ##1 !ce);
  COV_SIGNED:  cover property (ce && in.signA && in.signB);

endmodule : hard_multiplier_block

// >>> verif/operand_source.sv
// Fabric-side model: fresh random operands and sign controls every cycle.
// Assumes the bench owns the clock; outputs change only after rising edges.
`timescale 1ns/10ps
module operand_source
  import mult_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Operands to the block
  output mult_in_t  opnd
);
  integer seed = 49;

  initial opnd = '0;

  // Never wider than one block; wider products cascade outside
  always @(posedge mclk) opnd <= 38'({$random(seed), $random(seed)});
endmodule : operand_source

// >>> verif/hard_multiplier_block_tb.sv
// Bench for the multiplier block: every configuration, random ce and aclr.
// Assumes operand_source as the fabric; model updates with the design's edges.
`timescale 1ns/10ps
module hard_multiplier_block_tb;
  import mult_pkg::*;
  logic        mclk = 0, nrst = 0, ce = 0, aclr = 0;
  mult_cfg_t   cfg = '0;
  mult_in_t    opnd;
  mult_out_t   res;
  integer      seed = 49, failures = 0, tests_run = 0, cycles = 0;
  logic [17:0] qA = 0, qB = 0;
  logic        qsA = 0, qsB = 0, expS = 0;
  logic [35:0] expP = 0;
  logic [36:0] expW = 0;

  always #2 mclk = ~mclk;

  hard_multiplier_block u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .aclr(aclr),
                               .cfg(cfg), .in(opnd), .out(res));
  operand_source u_src (.mclk(mclk), .opnd(opnd));

  function automatic logic [35:0] lane(logic [17:0] a, b, int w, logic sa, sb);
    longint x, y;
    x = a & ((64'sd1 << w) - 1);
    y = b & ((64'sd1 << w) - 1);
    if (sa && a[w-1]) x -= (64'sd1 << w);
    if (sb && b[w-1]) y -= (64'sd1 << w);
    return 36'(x * y) & ((36'h1 << 2 * w) - 1);
  endfunction : lane

  always @(posedge mclk) begin
    logic [17:0] a, b;
    logic        sa, sb;
    a = cfg.regA ? qA : opnd.dataA;
    b = cfg.regB ? qB : opnd.dataB;
    sa = cfg.regSign ? qsA : opnd.signA;
    sb = cfg.regSign ? qsB : opnd.signB;
    if (!nrst || aclr) begin
      {qA, qB, qsA, qsB, expP, expS} = '0;
    end else if (ce) begin
      expP = cfg.dual ? (lane(a[17:9], b[17:9], 9, sa, sb) << 18) | lane(a, b, 9, sa, sb)
                      : lane(a, b, 18, sa, sb);
      expS = sa | sb;
      {qA, qB, qsA, qsB} = {opnd.dataA, opnd.dataB, opnd.signA, opnd.signB};
    end
  end

  // Clear shows before the next edge, so expect zero while it is high
  always @(negedge mclk) begin
    if (nrst) begin
      tests_run++;
      expW = aclr ? 37'h0 : {expP, expS};
      if (res !== expW) begin
        failures++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, expW, res);
      end
    end
  end

  task automatic final_report;
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1;
    ce <= 1;
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk) begin
        cfg <= mult_cfg_t'(c[3:0]);
        nrst <= (c != 9); // Mid-run synchronous reset
      end
      repeat (40) @(posedge mclk) begin
        nrst <= 1'b1;
        ce <= ($random(seed) & 3) != 0;
        aclr <= ($random(seed) & 31) == 0;
      end
    end
    final_report();
  end
endmodule : hard_multiplier_block_tb
